// *** pkg/hbs_pkg.sv ***
package hbs_pkg;
	// Register byte offsets
	localparam logic [7:0] HBS_CTRL_OFS = 8'h00;
	localparam logic [7:0] HBS_ACCEPT_OFS = 8'h04;
	localparam logic [7:0] HBS_STATIC_OFS = 8'h08;
	localparam logic [7:0] HBS_SPDTHR_OFS = 8'h0C;
	localparam logic [7:0] HBS_ROTTO_OFS = 8'h10;
	localparam logic [7:0] HBS_STATUS_OFS = 8'h14;
	// Control field
	localparam int HBS_CTRL_ASSIGNED_BIT = 0;
	localparam logic HBS_CTRL_ASSIGNED_RST = 1'b1;
	// Reset values and ranges, ms or rpm
	localparam logic [11:0] HBS_ACCEPT_RST = 12'h0FA;
	localparam logic [11:0] HBS_ACCEPT_MIN = 12'h000;
	localparam logic [11:0] HBS_ACCEPT_MAX = 12'h1F4;
	localparam logic [11:0] HBS_STATIC_RST = 12'h096;
	localparam logic [11:0] HBS_STATIC_MIN = 12'h001;
	localparam logic [11:0] HBS_STATIC_MAX = 12'h3E8;
	localparam logic [11:0] HBS_SPDTHR_RST = 12'h01E;
	localparam logic [11:0] HBS_SPDTHR_MIN = 12'h000;
	localparam logic [11:0] HBS_SPDTHR_MAX = 12'hBB8;
	localparam logic [11:0] HBS_ROTTO_RST = 12'h1F4;
	localparam logic [11:0] HBS_ROTTO_MIN = 12'h001;
	localparam logic [11:0] HBS_ROTTO_MAX = 12'h3E8;
	// Fixed figures
	localparam logic [15:0] HBS_ROTATING_RPM = 16'h0014;
	localparam logic [11:0] HBS_ROT_HOLD_MS = 12'h032;
	// Time base
	localparam int HBS_CLK_MHZ = 250;
	localparam int HBS_MS_NS = 1000000;
	localparam int HBS_CYC_PER_MS = HBS_MS_NS / 1000 * HBS_CLK_MHZ;
	// AXI responses
	localparam logic [1:0] HBS_RESP_OKAY = 2'h0;
	localparam logic [1:0] HBS_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		HBS_IDLE = 3'h0,
		HBS_RUN = 3'h1,
		HBS_ROT_WAIT = 3'h3,
		HBS_ROT_HOLD = 3'h2,
		HBS_STAT_HOLD = 3'h5,
		HBS_FAULT = 3'h4
	} hbs_state_t;
endpackage : hbs_pkg

// *** src/hbs_brake_sequencer.sv ***
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module hbs_brake_sequencer #(
	parameter int CYC_PER_MS = hbs_pkg::HBS_CYC_PER_MS
)(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Drive inputs
	input wire logic servoEnable,
	input wire logic driveFault,
	input wire logic [15:0] speedRpm,
	// Sequencer outputs
	output logic brakeRelease,
	output logic motorEnergize,
	output logic zeroSpeedStop,
	output logic cmdAccept
);
	localparam int PW = $clog2(CYC_PER_MS + 1);

	function automatic logic [11:0] clampVal(input logic [31:0] v,
		input logic [11:0] lo, input logic [11:0] hi);
		if (v > {20'h0, hi})
			return hi;
		if (v < {20'h0, lo})
			return lo;
		return v[11:0];
	endfunction : clampVal

	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : mergeBytes

	// Pin synchronisers; speed comes from same-clock estimator logic
	logic [1:0] enSync_r, fltSync_r;
	logic en, flt;
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
		begin
			enSync_r <= 2'h0;
			fltSync_r <= 2'h0;
		end
		else
		begin
			enSync_r <= {enSync_r[0], servoEnable};
			fltSync_r <= {fltSync_r[0], driveFault};
		end
	assign en = enSync_r[1];
	assign flt = fltSync_r[1];

	// Registers
	logic assigned_r, assigned_nxt;
	logic [11:0] acceptDly_r, acceptDly_nxt, staticDly_r, staticDly_nxt;
	logic [11:0] spdThr_r, spdThr_nxt, rotTo_r, rotTo_nxt;
	hbs_pkg::hbs_state_t state_r, state_nxt;
	logic [PW-1:0] presc_r, presc_nxt;
	logic [11:0] ms_r, ms_nxt;
	logic brake_nxt, energize_nxt, zero_nxt, accept_nxt;

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			hbs_pkg::HBS_IDLE:
				if (en)
					state_nxt = hbs_pkg::HBS_RUN;
			hbs_pkg::HBS_RUN:
				if (!en)
				begin
					if (speedRpm >= hbs_pkg::HBS_ROTATING_RPM)
						state_nxt = hbs_pkg::HBS_ROT_WAIT;
					else
						state_nxt = hbs_pkg::HBS_STAT_HOLD;
				end
			hbs_pkg::HBS_ROT_WAIT:
				if (speedRpm <= {4'h0, spdThr_r}
					|| ms_r >= rotTo_r)
					state_nxt = hbs_pkg::HBS_ROT_HOLD;
			hbs_pkg::HBS_ROT_HOLD:
				if (ms_r >= hbs_pkg::HBS_ROT_HOLD_MS)
					state_nxt = hbs_pkg::HBS_IDLE;
			hbs_pkg::HBS_STAT_HOLD:
				if (ms_r >= staticDly_r)
					state_nxt = hbs_pkg::HBS_IDLE;
			hbs_pkg::HBS_FAULT:
				if (!en)
					state_nxt = hbs_pkg::HBS_IDLE;
			default:
				state_nxt = hbs_pkg::HBS_FAULT;
		endcase
		if (flt)
			state_nxt = hbs_pkg::HBS_FAULT;
		// Time base restarts on every state entry, so delays are exact
		presc_nxt = '0;
		ms_nxt = '0;
		if (state_nxt == state_r)
		begin
			ms_nxt = ms_r;
			presc_nxt = presc_r + PW'(1);
			if (presc_r == PW'(CYC_PER_MS - 1))
			begin
				presc_nxt = '0;
				if (ms_r != 12'hFFF)
					ms_nxt = ms_r + 12'h001;
			end
		end
		energize_nxt = state_nxt inside {hbs_pkg::HBS_RUN,
			hbs_pkg::HBS_ROT_WAIT, hbs_pkg::HBS_ROT_HOLD,
			hbs_pkg::HBS_STAT_HOLD};
		brake_nxt = assigned_r && state_nxt inside {hbs_pkg::HBS_RUN,
			hbs_pkg::HBS_ROT_WAIT};
		zero_nxt = state_nxt == hbs_pkg::HBS_ROT_WAIT;
		accept_nxt = state_nxt == hbs_pkg::HBS_RUN
			&& (!assigned_r || ms_nxt >= acceptDly_r);
	end

	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
		begin
			state_r <= hbs_pkg::HBS_IDLE;
			presc_r <= '0;
			ms_r <= 12'h000;
			brakeRelease <= 1'b0;
			motorEnergize <= 1'b0;
			zeroSpeedStop <= 1'b0;
			cmdAccept <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			presc_r <= presc_nxt;
			ms_r <= ms_nxt;
			brakeRelease <= brake_nxt;
			motorEnergize <= energize_nxt;
			zeroSpeedStop <= zero_nxt;
			cmdAccept <= accept_nxt;
		end

	// AXI4-Lite slave: address and data taken together, answer next cycle
	logic wrGo, rdGo;
	logic bvalid_nxt, rvalid_nxt;
	logic [1:0] bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt, wword;
	// Decoded words: bit 32 marks a mapped offset
	logic [32:0] wrReg, rdReg;
	logic [31:0] status;
	assign s_axi_awready = !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
	assign s_axi_wready = s_axi_awready;
	assign s_axi_arready = !s_axi_rvalid;
	assign wrGo = s_axi_awready;
	assign rdGo = s_axi_arvalid && s_axi_arready;
	assign status = {24'h0, 1'b0, state_r, zeroSpeedStop, cmdAccept,
		motorEnergize, brakeRelease};

	function automatic logic [32:0] readReg(input logic [7:0] a);
		case (a)
			hbs_pkg::HBS_CTRL_OFS: return {1'b1, 31'h0, assigned_r};
			hbs_pkg::HBS_ACCEPT_OFS: return {1'b1, 20'h0, acceptDly_r};
			hbs_pkg::HBS_STATIC_OFS: return {1'b1, 20'h0, staticDly_r};
			hbs_pkg::HBS_SPDTHR_OFS: return {1'b1, 20'h0, spdThr_r};
			hbs_pkg::HBS_ROTTO_OFS: return {1'b1, 20'h0, rotTo_r};
			hbs_pkg::HBS_STATUS_OFS: return {1'b1, status};
			default: return 33'h0;
		endcase
	endfunction : readReg

	always_comb
	begin
		assigned_nxt = assigned_r;
		acceptDly_nxt = acceptDly_r;
		staticDly_nxt = staticDly_r;
		spdThr_nxt = spdThr_r;
		rotTo_nxt = rotTo_r;
		wrReg = readReg(s_axi_awaddr);
		rdReg = readReg(s_axi_araddr);
		wword = mergeBytes(wrReg[31:0], s_axi_wdata, s_axi_wstrb);
		bvalid_nxt = s_axi_bvalid && !s_axi_bready;
		bresp_nxt = s_axi_bresp;
		if (wrGo)
		begin
			bvalid_nxt = 1'b1;
			bresp_nxt = wrReg[32] ? hbs_pkg::HBS_RESP_OKAY
				: hbs_pkg::HBS_RESP_SLVERR;
			// Writes clamp to the legal range rather than fault
			case (s_axi_awaddr)
				hbs_pkg::HBS_CTRL_OFS:
					assigned_nxt = wword[hbs_pkg::HBS_CTRL_ASSIGNED_BIT];
				hbs_pkg::HBS_ACCEPT_OFS:
					acceptDly_nxt = clampVal(wword, hbs_pkg::HBS_ACCEPT_MIN,
						hbs_pkg::HBS_ACCEPT_MAX);
				hbs_pkg::HBS_STATIC_OFS:
					staticDly_nxt = clampVal(wword, hbs_pkg::HBS_STATIC_MIN,
						hbs_pkg::HBS_STATIC_MAX);
				hbs_pkg::HBS_SPDTHR_OFS:
					spdThr_nxt = clampVal(wword, hbs_pkg::HBS_SPDTHR_MIN,
						hbs_pkg::HBS_SPDTHR_MAX);
				hbs_pkg::HBS_ROTTO_OFS:
					rotTo_nxt = clampVal(wword, hbs_pkg::HBS_ROTTO_MIN,
						hbs_pkg::HBS_ROTTO_MAX);
				default:
					assigned_nxt = assigned_r;
			endcase
		end
		rvalid_nxt = s_axi_rvalid && !s_axi_rready;
		rresp_nxt = s_axi_rresp;
		rdata_nxt = s_axi_rdata;
		if (rdGo)
		begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rdReg[31:0];
			rresp_nxt = rdReg[32] ? hbs_pkg::HBS_RESP_OKAY
				: hbs_pkg::HBS_RESP_SLVERR;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
		begin
			assigned_r <= hbs_pkg::HBS_CTRL_ASSIGNED_RST;
			acceptDly_r <= hbs_pkg::HBS_ACCEPT_RST;
			staticDly_r <= hbs_pkg::HBS_STATIC_RST;
			spdThr_r <= hbs_pkg::HBS_SPDTHR_RST;
			rotTo_r <= hbs_pkg::HBS_ROTTO_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0;
		end
		else
		begin
			assigned_r <= assigned_nxt;
			acceptDly_r <= acceptDly_nxt;
			staticDly_r <= staticDly_nxt;
			spdThr_r <= spdThr_nxt;
			rotTo_r <= rotTo_nxt;
			s_axi_bvalid <= bvalid_nxt;
			s_axi_bresp <= bresp_nxt;
			s_axi_rvalid <= rvalid_nxt;
			s_axi_rresp <= rresp_nxt;
			s_axi_rdata <= rdata_nxt;
		end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence stopStationary;
		state_r == hbs_pkg::HBS_RUN && !en && !flt
			&& speedRpm < hbs_pkg::HBS_ROTATING_RPM;
	endsequence
	sequence stopRotating;
		state_r == hbs_pkg::HBS_RUN && !en && !flt
			&& speedRpm >= hbs_pkg::HBS_ROTATING_RPM;
	endsequence

	stat_brake_a: assert property (stopStationary |=> !brakeRelease
		&& motorEnergize && state_r == hbs_pkg::HBS_STAT_HOLD)
		else $error("brake release not dropped on stationary stop");
	stat_hold_a: assert property (state_r == hbs_pkg::HBS_STAT_HOLD
		&& ms_r < staticDly_r && !flt |=> motorEnergize
		&& state_r == hbs_pkg::HBS_STAT_HOLD)
		else $error("power removed before static delay");
	rot_select_a: assert property (stopRotating |=>
		state_r == hbs_pkg::HBS_ROT_WAIT)
		else $error("rotating stop not selected");
	rot_wait_a: assert property (state_r == hbs_pkg::HBS_ROT_WAIT |->
		zeroSpeedStop && motorEnergize && brakeRelease == assigned_r)
		else $error("rotating wait outputs wrong");
	thr_drop_a: assert property (state_r == hbs_pkg::HBS_ROT_WAIT
		&& speedRpm <= {4'h0, spdThr_r} |=> !brakeRelease)
		else $error("brake release kept below threshold");
	rot_timeout_a: assert property (state_r == hbs_pkg::HBS_ROT_WAIT
		&& ms_r >= rotTo_r |=> !brakeRelease)
		else $error("brake release kept after timeout");
	rot_hold_a: assert property (state_r == hbs_pkg::HBS_ROT_HOLD
		&& ms_r < hbs_pkg::HBS_ROT_HOLD_MS && !flt |=> motorEnergize)
		else $error("power removed within 50 ms hold");
	fault_stop_a: assert property (flt |=> !motorEnergize
		&& !brakeRelease && !cmdAccept)
		else $error("fault did not coast and brake");
	accept_gate_a: assert property (cmdAccept |->
		state_r == hbs_pkg::HBS_RUN && (!assigned_r || ms_r >= acceptDly_r))
		else $error("commands accepted too early");
	accept_range_a: assert property (acceptDly_r <= hbs_pkg::HBS_ACCEPT_MAX
		&& staticDly_r >= hbs_pkg::HBS_STATIC_MIN)
		else $error("delay register out of range");
endmodule : hbs_brake_sequencer
`default_nettype wire

// *** test/hbs_motion_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module hbs_motion_partner (
	// Clock
	input wire logic ref_clk,
	// Bench control
	input wire logic loadSpeed,
	input wire logic [15:0] loadVal,
	input wire logic [15:0] decStep,
	input wire logic cmdWant,
	// Sequencer side
	input wire logic zeroSpeedStop,
	input wire logic cmdAccept,
	output logic [15:0] speedRpm,
	output logic cmdIssue
);
	// Slows only under a stop command; zero step models a stalled load
	always_ff @(posedge ref_clk)
	begin
		if (loadSpeed)
			speedRpm <= loadVal;
		else if (zeroSpeedStop)
			speedRpm <= (speedRpm > decStep) ? speedRpm - decStep : 16'h0000;
	end
	// Controller holds motion commands back while the gate is shut
	assign cmdIssue = cmdWant & cmdAccept;
endmodule : hbs_motion_partner
`default_nettype wire

// *** test/tb_holding_brake_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_holding_brake_sequencer;
	localparam int C = 10;
	localparam logic [31:0] RST_V [6] = '{1, 32'hFA, 32'h96, 32'h1E, 32'h1F4, 0};
	localparam logic [31:0] CL_IN [4] = '{32'h3FF, 0, 32'hFFF, 0};
	localparam logic [31:0] CL_OUT [4] = '{32'h1F4, 1, 32'hBB8, 1};
	localparam logic [31:0] WORK [4] = '{3, 2, 32'h1E, 5};
	logic ref_clk, resetn, servoEnable, driveFault, loadSpeed, cmdWant, cmdIssue;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [15:0] speedRpm, loadVal, decStep;
	logic brakeRelease, motorEnergize, zeroSpeedStop, cmdAccept;
	logic [3:0] outs;
	int errorCnt, nChecks, n;
	assign outs = {cmdAccept, zeroSpeedStop, motorEnergize, brakeRelease};
	hbs_brake_sequencer #(.CYC_PER_MS(C)) uut (
		.ref_clk(ref_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.servoEnable(servoEnable), .driveFault(driveFault),
		.speedRpm(speedRpm), .brakeRelease(brakeRelease),
		.motorEnergize(motorEnergize), .zeroSpeedStop(zeroSpeedStop),
		.cmdAccept(cmdAccept)
	);
	hbs_motion_partner motor (
		.ref_clk(ref_clk), .loadSpeed(loadSpeed), .loadVal(loadVal),
		.decStep(decStep), .cmdWant(cmdWant), .zeroSpeedStop(zeroSpeedStop),
		.cmdAccept(cmdAccept), .speedRpm(speedRpm), .cmdIssue(cmdIssue)
	);
	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chkVal
	task automatic chkSpan(input int got, input int lo, input int hi);
		nChecks++;
		if (got < lo || got > hi)
		begin
			errorCnt++;
			$display("mismatch at %0t: %0d cycles", $time, got);
		end
	endtask : chkSpan
	task automatic waitBit(input int b, input logic v);
		n = 0;
		while (outs[b] !== v && n < 2000)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 2000)
		begin
			errorCnt++;
			$display("mismatch at %0t: output %0d never settled", $time, b);
		end
	endtask : waitBit
	task automatic axiWr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_awready);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge ref_clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axiWr
	task automatic axiRd(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axiRd
	task automatic enable(input logic v);
		@(posedge ref_clk);
		servoEnable <= v;
	endtask : enable
	// Speed is loaded only while the motor is de-energised, so the stop command never races it
	task automatic cycleRun(input logic [15:0] s, input logic [15:0] st);
		@(posedge ref_clk);
		loadSpeed <= 1'b1;
		loadVal <= s;
		decStep <= st;
		@(posedge ref_clk);
		loadSpeed <= 1'b0;
		enable(1'b1);
		waitBit(3, 1'b1);
		enable(1'b0);
	endtask : cycleRun
	task automatic results;
		if (errorCnt == 0 && nChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial
	begin
		#200000;
		errorCnt++;
		results();
	end
	initial
	begin
		{resetn, servoEnable, driveFault, cmdWant, s_axi_awvalid} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, decStep} = '0;
		loadSpeed = 1'b1;
		loadVal = 16'h0000;
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		cmdWant <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			axiRd(8'(4 * i));
			chkVal(d, RST_V[i]);
		end
		axiRd(8'h18);
		chkVal(d, 32'h0);
		chkVal(32'(r), 32'(hbs_pkg::HBS_RESP_SLVERR));
		axiWr(8'h18, 32'h5);
		chkVal(32'(r), 32'(hbs_pkg::HBS_RESP_SLVERR));
		for (int i = 0; i < 4; i++)
		begin
			axiWr(8'(4 * i + 4), CL_IN[i]);
			axiRd(8'(4 * i + 4));
			chkVal(d, CL_OUT[i]);
			axiWr(8'(4 * i + 4), WORK[i]);
		end
		enable(1'b1);
		waitBit(0, 1'b1);
		chkVal(32'(cmdIssue), 32'h0);
		waitBit(3, 1'b1);
		chkSpan(n, 3 * C - 3, 3 * C + 5);
		chkVal(32'(cmdIssue), 32'h1);
		axiRd(hbs_pkg::HBS_STATUS_OFS);
		chkVal(d, 32'h17);
		driveFault <= 1'b1;
		waitBit(1, 1'b0);
		chkSpan(n, 2, 5);
		chkVal(32'(outs), 32'h0);
		driveFault <= 1'b0;
		servoEnable <= 1'b0;
		cycleRun(16'h0013, 16'h0000);
		waitBit(0, 1'b0);
		chkSpan(n, 2, 5);
		chkVal(32'(outs[2:1]), 32'h1);
		waitBit(1, 1'b0);
		chkSpan(n, 2 * C - 3, 2 * C + 5);
		cycleRun(16'h0064, 16'h0005);
		waitBit(2, 1'b1);
		chkVal(32'(outs[1:0]), 32'h3);
		waitBit(0, 1'b0);
		chkSpan(n, 13, 18);
		waitBit(1, 1'b0);
		chkSpan(n, 50 * C - 3, 50 * C + 5);
		axiWr(hbs_pkg::HBS_SPDTHR_OFS, 32'h0);
		cycleRun(16'h0014, 16'h0000);
		waitBit(2, 1'b1);
		chkSpan(n, 2, 5);
		waitBit(0, 1'b0);
		chkSpan(n, 5 * C - 3, 5 * C + 5);
		waitBit(1, 1'b0);
		axiWr(hbs_pkg::HBS_CTRL_OFS, 32'h0);
		enable(1'b1);
		waitBit(3, 1'b1);
		chkSpan(n, 2, 6);
		chkVal(32'(outs[0]), 32'h0);
		results();
	end
endmodule : tb_holding_brake_sequencer
`default_nettype wire
